// ==== rqsm_top.sv ====
// queue switch and mark control for the read and write ports
// assumes both ports run on clk_in; enables here are active high
`timescale 1ns/1ps
`default_nettype none
`include "rqsm_defs.svh"

module rqsm_top (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic first_word_fallthrough_mode_in,
  input wire logic packet_mode_in,
  input wire logic [`RQSM_QADDR_W-1:0] read_queue_select_bus_in,
  input wire logic read_select_strobe_in,
  input wire logic read_enable_in,
  input wire logic read_packet_start_in,
  input wire logic [`RQSM_QADDR_W-1:0] write_queue_select_bus_in,
  input wire logic write_select_strobe_in,
  input wire logic write_enable_in,
  input wire logic write_packet_start_in,
  input wire logic [`RQSM_QUEUES-1:0] empty_status_in,
  input wire logic [`RQSM_QUEUES-1:0] almost_empty_status_in,
  input wire logic [`RQSM_QUEUES-1:0] packet_ready_status_in,
  output logic almost_empty_flag_out,
  output logic packet_ready_flag_out,
  output logic empty_indicator_out,
  output logic output_ready_out,
  output logic read_access_out,
  output logic [`RQSM_QADDR_W-1:0] read_queue_out,
  output logic [`RQSM_POS_W-1:0] read_position_counter_out,
  output logic read_switch_busy_out,
  output logic read_mark_valid_out,
  output logic [`RQSM_QADDR_W-1:0] read_mark_queue_out,
  output logic [`RQSM_POS_W-1:0] read_mark_position_out,
  output logic read_illegal_switch_out,
  output logic write_access_out,
  output logic [`RQSM_QADDR_W-1:0] write_queue_out,
  output logic [`RQSM_POS_W-1:0] write_position_counter_out,
  output logic write_switch_busy_out,
  output logic write_mark_valid_out,
  output logic [`RQSM_QADDR_W-1:0] write_mark_queue_out,
  output logic [`RQSM_POS_W-1:0] write_mark_position_out,
  output logic write_illegal_switch_out
);

  // per-port views, index 0 is read, index 1 is write
  logic strobe_w [`RQSM_PORTS];
  logic [`RQSM_QADDR_W-1:0] sel_w [`RQSM_PORTS];
  logic en_w [`RQSM_PORTS];
  logic pkt_start_w [`RQSM_PORTS];
  rqsm_pkg::rqsm_phase_t phase_w [`RQSM_PORTS];
  logic flag_cyc_w [`RQSM_PORTS];
  // accept and first-access markers stay inside the sequencer
  logic [`RQSM_QADDR_W-1:0] present_w [`RQSM_PORTS];
  logic [`RQSM_QADDR_W-1:0] next_w [`RQSM_PORTS];
  logic cont_w [`RQSM_PORTS];
  logic mark_req_w [`RQSM_PORTS];
  logic access_w [`RQSM_PORTS];
  logic [`RQSM_POS_W-1:0] pos_w [`RQSM_PORTS];
  logic mark_v_w [`RQSM_PORTS];
  logic [`RQSM_QADDR_W-1:0] mark_q_w [`RQSM_PORTS];
  logic [`RQSM_POS_W-1:0] mark_pos_w [`RQSM_PORTS];
  logic illegal_w [`RQSM_PORTS];

  assign strobe_w[`RQSM_PORT_RD] = read_select_strobe_in;
  assign strobe_w[`RQSM_PORT_WR] = write_select_strobe_in;
  assign sel_w[`RQSM_PORT_RD] = read_queue_select_bus_in;
  assign sel_w[`RQSM_PORT_WR] = write_queue_select_bus_in;
  assign en_w[`RQSM_PORT_RD] = read_enable_in;
  assign en_w[`RQSM_PORT_WR] = write_enable_in;
  assign pkt_start_w[`RQSM_PORT_RD] = read_packet_start_in;
  assign pkt_start_w[`RQSM_PORT_WR] = write_packet_start_in;

  // two independent ports; no shared state, so simultaneous switches never interact
  genvar p;
  generate
    for (p = 0; p < `RQSM_PORTS; p = p + 1)
    begin : g_port
      logic [`RQSM_POS_W-1:0] saved_r [`RQSM_QUEUES];
      logic [`RQSM_POS_W-1:0] pos_r;
      logic [`RQSM_POS_W-1:0] pos_adv;
      logic mark_v_r;
      logic [`RQSM_QADDR_W-1:0] mark_q_r;
      logic [`RQSM_POS_W-1:0] mark_pos_r;
      logic illegal_r;
      logic freeze;
      logic pq_marked;
      logic same_q;

      rqsm_switch_seq u_seq (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .select_strobe_in(strobe_w[p]),
        .queue_select_bus_in(sel_w[p]),
        .access_enable_in(en_w[p]),
        .phase_out(phase_w[p]),
        .switch_accept_out(),
        .flag_update_cycle_out(flag_cyc_w[p]),
        .new_queue_access_cycle_out(),
        .present_queue_out(present_w[p]),
        .next_queue_out(next_w[p]),
        .continue_access_out(cont_w[p]),
        .mark_request_out(mark_req_w[p])
      );

      // idle enable at the request freezes the present pointer until the switch ends
      assign freeze = (phase_w[p] != rqsm_pkg::rqsm_idle) && !cont_w[p];
      // otherwise access to the present queue carries on through the switch
      assign access_w[p] = en_w[p] && !freeze;
      assign pos_adv = access_w[p] ? pos_r + `RQSM_POS_ONE : pos_r;
      assign pq_marked = mark_v_r && (mark_q_r == present_w[p]);
      assign same_q = (next_w[p] == present_w[p]);

      // saved return positions; written only for the queue being left
      always_ff @(posedge clk_in)
      begin
        if (rst_in)
        begin
          for (int i = 0; i < `RQSM_QUEUES; i++)
            saved_r[i] <= `RQSM_POS_ZERO;
        end
        else if (flag_cyc_w[p] && !same_q)
        begin
          if (pq_marked && !cont_w[p])
            saved_r[present_w[p]] <= mark_pos_r;
          else
            saved_r[present_w[p]] <= pos_adv;
        end
      end

      // working position of the present queue
      always_ff @(posedge clk_in)
      begin
        if (rst_in)
          pos_r <= `RQSM_POS_ZERO;
        else if (flag_cyc_w[p] && !same_q)
          pos_r <= saved_r[next_w[p]];
        else if (flag_cyc_w[p] && pq_marked && !cont_w[p])
          pos_r <= mark_pos_r;
        else
          pos_r <= pos_adv;
      end

      // mark register: one per port, decided at the end of the switch
      always_ff @(posedge clk_in)
      begin
        if (rst_in)
        begin
          mark_v_r <= 1'b0;
          mark_q_r <= `RQSM_Q_ZERO;
          mark_pos_r <= `RQSM_POS_ZERO;
        end
        else if (flag_cyc_w[p])
        begin
          if (!same_q)
          begin
            // strobe level in the decision cycle marks or unmarks the next queue
            mark_v_r <= mark_req_w[p];
            mark_q_r <= next_w[p];
            mark_pos_r <= saved_r[next_w[p]];
          end
          else if (!pq_marked)
          begin
            // plain self switch is ignored; a mark request marks here
            if (mark_req_w[p])
            begin
              mark_v_r <= 1'b1;
              mark_q_r <= present_w[p];
              mark_pos_r <= pos_adv;
            end
          end
          else if (!cont_w[p])
            mark_v_r <= mark_req_w[p];
          // marked self switch without re-read leaves everything alone
        end
        else if (packet_mode_in && access_w[p] && pkt_start_w[p] && pq_marked)
          mark_pos_r <= pos_r;
      end

      // report the disallowed self switch rather than act on it
      always_ff @(posedge clk_in)
      begin
        if (rst_in)
          illegal_r <= 1'b0;
        else
          illegal_r <= flag_cyc_w[p] && same_q && pq_marked && cont_w[p];
      end

      assign pos_w[p] = pos_r;
      assign mark_v_w[p] = mark_v_r;
      assign mark_q_w[p] = mark_q_r;
      assign mark_pos_w[p] = mark_pos_r;
      assign illegal_w[p] = illegal_r;
    end
  endgenerate

  // read flags track the queue the flags describe: next queue from the flag cycle on
  logic [`RQSM_QADDR_W-1:0] flag_q;
  logic pae_r;
  logic pr_r;
  logic ef_r;
  logic or_r;

  assign flag_q = flag_cyc_w[`RQSM_PORT_RD] ? next_w[`RQSM_PORT_RD] : present_w[`RQSM_PORT_RD];

  // almost empty and packet ready switch in the flag cycle in either mode
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      pae_r <= 1'b0;
      pr_r <= 1'b0;
    end
    else
    begin
      pae_r <= almost_empty_status_in[flag_q];
      pr_r <= packet_ready_status_in[flag_q];
    end
  end

  // empty follows the flag cycle in standard mode, the present queue otherwise
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      ef_r <= 1'b1;
    else if (!first_word_fallthrough_mode_in)
      ef_r <= empty_status_in[flag_q];
    else
      ef_r <= empty_status_in[present_w[`RQSM_PORT_RD]];
  end

  // fall-through ready lags to the cycle after the first access cycle of the new queue
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      or_r <= 1'b0;
    else
      or_r <= first_word_fallthrough_mode_in && !empty_status_in[present_w[`RQSM_PORT_RD]];
  end

  assign almost_empty_flag_out = pae_r;
  assign packet_ready_flag_out = pr_r;
  assign empty_indicator_out = ef_r;
  assign output_ready_out = or_r;

  assign read_access_out = access_w[`RQSM_PORT_RD];
  assign read_queue_out = present_w[`RQSM_PORT_RD];
  assign read_position_counter_out = pos_w[`RQSM_PORT_RD];
  assign read_switch_busy_out = phase_w[`RQSM_PORT_RD] != rqsm_pkg::rqsm_idle;
  assign read_mark_valid_out = mark_v_w[`RQSM_PORT_RD];
  assign read_mark_queue_out = mark_q_w[`RQSM_PORT_RD];
  assign read_mark_position_out = mark_pos_w[`RQSM_PORT_RD];
  assign read_illegal_switch_out = illegal_w[`RQSM_PORT_RD];

  assign write_access_out = access_w[`RQSM_PORT_WR];
  assign write_queue_out = present_w[`RQSM_PORT_WR];
  assign write_position_counter_out = pos_w[`RQSM_PORT_WR];
  assign write_switch_busy_out = phase_w[`RQSM_PORT_WR] != rqsm_pkg::rqsm_idle;
  assign write_mark_valid_out = mark_v_w[`RQSM_PORT_WR];
  assign write_mark_queue_out = mark_q_w[`RQSM_PORT_WR];
  assign write_mark_position_out = mark_pos_w[`RQSM_PORT_WR];
  assign write_illegal_switch_out = illegal_w[`RQSM_PORT_WR];

endmodule : rqsm_top

`default_nettype wire

// ==== rqsm_defs.svh ====
// constants for the queue switch and mark block
// assumes a single 10 MHz clock feeds both port sequencers
`ifndef RQSM_DEFS_SVH
`define RQSM_DEFS_SVH

`define RQSM_QUEUES 128
`define RQSM_QADDR_W 7
`define RQSM_POS_W 10
`define RQSM_PORT_RD 0
`define RQSM_PORT_WR 1
`define RQSM_PORTS 2
`define RQSM_Q_ZERO 7'h00
`define RQSM_POS_ZERO 10'h000
`define RQSM_POS_ONE 10'h001

`endif

// ==== rqsm_pkg.sv ====
// types shared by the queue switch sequencer and the top
// assumes rqsm_defs.svh is not needed here; types only
package rqsm_pkg;

  // switch phases after the request cycle; idle doubles as the first access cycle
  typedef enum logic [1:0] {
    rqsm_idle,
    rqsm_mark_decide,
    rqsm_hold,
    rqsm_flag_update
  } rqsm_phase_t;

endpackage : rqsm_pkg

// ==== rqsm_switch_seq.sv ====
// one port's four-cycle queue switch sequencer
// assumes select strobe and bus are synchronous to clk_in
`timescale 1ns/1ps
`default_nettype none
`include "rqsm_defs.svh"

module rqsm_switch_seq (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic select_strobe_in,
  input wire logic [`RQSM_QADDR_W-1:0] queue_select_bus_in,
  input wire logic access_enable_in,
  output var rqsm_pkg::rqsm_phase_t phase_out,
  output logic switch_accept_out,
  output logic flag_update_cycle_out,
  output logic new_queue_access_cycle_out,
  output logic [`RQSM_QADDR_W-1:0] present_queue_out,
  output logic [`RQSM_QADDR_W-1:0] next_queue_out,
  output logic continue_access_out,
  output logic mark_request_out
);

  rqsm_pkg::rqsm_phase_t phase_r;
  logic [`RQSM_QADDR_W-1:0] present_r;
  logic [`RQSM_QADDR_W-1:0] next_r;
  logic continue_r;
  logic mark_req_r;
  logic new_access_r;

  // a request is only taken when no switch is in flight; enable is ignored here
  assign switch_accept_out = (phase_r == rqsm_pkg::rqsm_idle) && select_strobe_in;

  // phase walk: request, mark decide, hold, flag update, then access
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      phase_r <= rqsm_pkg::rqsm_idle;
    else
    begin
      case (phase_r)
        rqsm_pkg::rqsm_idle: if (switch_accept_out) phase_r <= rqsm_pkg::rqsm_mark_decide;
        rqsm_pkg::rqsm_mark_decide: phase_r <= rqsm_pkg::rqsm_hold;
        rqsm_pkg::rqsm_hold: phase_r <= rqsm_pkg::rqsm_flag_update;
        rqsm_pkg::rqsm_flag_update: phase_r <= rqsm_pkg::rqsm_idle;
        default: phase_r <= rqsm_pkg::rqsm_idle;
      endcase
    end
  end

  // capture next queue and the continue/re-access choice in the request cycle
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      next_r <= `RQSM_Q_ZERO;
      continue_r <= 1'b1;
    end
    else if (switch_accept_out)
    begin
      next_r <= queue_select_bus_in;
      continue_r <= access_enable_in;
    end
  end

  // strobe level in the cycle after the request is the mark decision
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      mark_req_r <= 1'b0;
    else if (phase_r == rqsm_pkg::rqsm_mark_decide)
      mark_req_r <= select_strobe_in;
  end

  // queue address register moves at the end of the flag update cycle
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      present_r <= `RQSM_Q_ZERO;
    else if (phase_r == rqsm_pkg::rqsm_flag_update)
      present_r <= next_r;
  end

  // one-cycle marker for the first access of the new queue
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      new_access_r <= 1'b0;
    else
      new_access_r <= (phase_r == rqsm_pkg::rqsm_flag_update);
  end

  assign phase_out = phase_r;
  assign flag_update_cycle_out = (phase_r == rqsm_pkg::rqsm_flag_update);
  assign new_queue_access_cycle_out = new_access_r;
  assign present_queue_out = present_r;
  assign next_queue_out = next_r;
  assign continue_access_out = continue_r;
  assign mark_request_out = mark_req_r;

endmodule : rqsm_switch_seq

`default_nettype wire

// ==== rqsm_chk.sv ====
// checker for rqsm_top: read port switch timing, flags, marks
// assumes one clock domain and rst_in synchronous, active high
`timescale 1ns/1ps
`default_nettype none
`include "rqsm_defs.svh"

module rqsm_chk (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic first_word_fallthrough_mode_in,
  input wire logic packet_mode_in,
  input wire logic read_packet_start_in,
  input wire logic [`RQSM_POS_W-1:0] read_position_counter_out,
  input wire logic [`RQSM_POS_W-1:0] read_mark_position_out,
  input wire logic [`RQSM_QADDR_W-1:0] read_queue_select_bus_in,
  input wire logic read_select_strobe_in,
  input wire logic read_enable_in,
  input wire logic [`RQSM_QUEUES-1:0] empty_status_in,
  input wire logic [`RQSM_QUEUES-1:0] almost_empty_status_in,
  input wire logic [`RQSM_QUEUES-1:0] packet_ready_status_in,
  input wire logic almost_empty_flag_out,
  input wire logic packet_ready_flag_out,
  input wire logic empty_indicator_out,
  input wire logic read_access_out,
  input wire logic [`RQSM_QADDR_W-1:0] read_queue_out,
  input wire logic read_switch_busy_out,
  input wire logic read_mark_valid_out,
  input wire logic [`RQSM_QADDR_W-1:0] read_mark_queue_out,
  input wire logic read_illegal_switch_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  logic rreq;

  // a strobe only counts as a request while no switch is running
  assign rreq = read_select_strobe_in && !read_switch_busy_out;

  req_busy_a: assert property (rreq |=> read_switch_busy_out)
    else $error("request did not start a switch");
  busy_len_a: assert property ($rose(read_switch_busy_out) |->
    read_switch_busy_out [*3] ##1 !read_switch_busy_out)
    else $error("switch length wrong");
  queue_latch_a: assert property (rreq |->
    ##4 read_queue_out == $past(read_queue_select_bus_in, 4))
    else $error("selected queue not taken");
  flag_load_a: assert property ($fell(read_switch_busy_out) |->
    almost_empty_flag_out == almost_empty_status_in[read_queue_out]
    && packet_ready_flag_out == packet_ready_status_in[read_queue_out]
    && (first_word_fallthrough_mode_in || empty_indicator_out == empty_status_in[read_queue_out]))
    else $error("flags not loaded for new queue");
  frozen_read_a: assert property (rreq && !read_enable_in |=> !read_access_out [*3])
    else $error("frozen queue still read");
  keep_read_a: assert property (rreq && read_enable_in |=>
    (read_access_out == read_enable_in) [*3])
    else $error("reading stopped during switch");
  mark_read_a: assert property (rreq ##1 read_select_strobe_in |->
    ##3 read_mark_valid_out && read_mark_queue_out == read_queue_out)
    else $error("mark request not honoured");
  illegal_pulse_a: assert property (read_illegal_switch_out |=> !read_illegal_switch_out)
    else $error("illegal flag longer than a cycle");
  pos_step_a: assert property (!read_switch_busy_out |=>
    read_position_counter_out == ($past(read_access_out) ?
    $past(read_position_counter_out) + `RQSM_POS_ONE : $past(read_position_counter_out)))
    else $error("read position did not follow access");
  pkt_mark_a: assert property (packet_mode_in && read_access_out && read_packet_start_in
    && read_mark_valid_out && read_mark_queue_out == read_queue_out && !read_switch_busy_out
    |=> read_mark_position_out == $past(read_position_counter_out))
    else $error("mark did not move to packet start");
endmodule : rqsm_chk

bind rqsm_top rqsm_chk rqsm_chk_inst (.*);
`default_nettype wire

// ==== rqsm_far_port.sv ====
// far-side selector model: strobe, select bus and enable of one port
// assumes the bench calls go() and the block samples on the rising edge
`timescale 1ns/1ps
`default_nettype none
`include "rqsm_defs.svh"

module rqsm_far_port (
  input wire logic clk_in,
  output logic stb_out,
  output logic [`RQSM_QADDR_W-1:0] bus_out,
  output logic en_out
);
  // quiet at time zero
  initial
  begin
    stb_out = 1'b0;
    bus_out = 7'h00;
    en_out = 1'b0;
  end

  // request, mark choice, two quiet cycles; bus toggles once not sampled
  task automatic go(input logic [6:0] q, input logic e, m, c);
    @(negedge clk_in);
    stb_out = 1'b1;
    bus_out = q;
    en_out = e;
    @(negedge clk_in);
    stb_out = m;
    bus_out = ~q;
    en_out = c;
    @(negedge clk_in);
    stb_out = 1'b0;
    bus_out = q;
    @(negedge clk_in);
    bus_out = ~q;
  endtask : go
endmodule : rqsm_far_port
`default_nettype wire

// ==== tb_top.sv ====
// bench for rqsm_top: random and directed switches on both ports
// assumes rqsm_far_port drives the selects and rqsm_chk is bound
`timescale 1ns/1ps
`default_nettype none
`include "rqsm_defs.svh"

module tb_top;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [`RQSM_QUEUES-1:0] ae_s = '0, pr_s = '0, ef_s = '0;
  logic rs, re, ws, we, ae, pr, ef, rb, wb, rmv, wmv, ri;
  logic wi, ordy;
  logic fw = 1'b0, pm = 1'b0, rps = 1'b0, wps = 1'b0, or_due = 1'b0;
  logic [1:0] on [$];
  logic rb_d = 1'b0;
  logic wb_d = 1'b0;
  logic [6:0] rbus, wbus, rq, wq, rmq, wmq;
  logic [6:0] pq [2] = '{7'h00, 7'h00};
  logic mv [2] = '{1'b0, 1'b0};
  logic [17:0] rn [$], wn [$];
  logic [4:0] se = 5'h04, sm = 5'h0A;
  int failures = 0, n_compared = 0, n_ill = 0, ill_seen = 0;

  rqsm_far_port rd_port (.clk_in(clk_in), .stb_out(rs), .bus_out(rbus), .en_out(re));
  rqsm_far_port wr_port (.clk_in(clk_in), .stb_out(ws), .bus_out(wbus), .en_out(we));
  rqsm_top rqsm_top_inst (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .first_word_fallthrough_mode_in(fw),
    .packet_mode_in(pm),
    .read_queue_select_bus_in(rbus),
    .read_select_strobe_in(rs),
    .read_enable_in(re),
    .read_packet_start_in(rps),
    .write_queue_select_bus_in(wbus),
    .write_select_strobe_in(ws),
    .write_enable_in(we),
    .write_packet_start_in(wps),
    .empty_status_in(ef_s),
    .almost_empty_status_in(ae_s),
    .packet_ready_status_in(pr_s),
    .almost_empty_flag_out(ae),
    .packet_ready_flag_out(pr),
    .empty_indicator_out(ef),
    .output_ready_out(ordy),
    .read_access_out(),
    .read_queue_out(rq),
    .read_position_counter_out(),
    .read_switch_busy_out(rb),
    .read_mark_valid_out(rmv),
    .read_mark_queue_out(rmq),
    .read_mark_position_out(),
    .read_illegal_switch_out(ri),
    .write_access_out(),
    .write_queue_out(wq),
    .write_position_counter_out(),
    .write_switch_busy_out(wb),
    .write_mark_valid_out(wmv),
    .write_mark_queue_out(wmq),
    .write_mark_position_out(),
    .write_illegal_switch_out(wi)
  );

  // 10 MHz clock
  initial forever #50 clk_in = ~clk_in;

  task automatic check(input logic [17:0] seen, input logic [17:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // model the mark outcome, note it, then have the far side request
  task automatic sw(input int p, input logic [6:0] q, input logic e, m, c);
    logic [6:0] old;
    if (q != pq[p] || !mv[p] || !e) mv[p] = m;
    else n_ill++;
    old = pq[p];
    pq[p] = q;
    // fall-through empty stays on the old queue until the new one is in use
    if (p == 0) rn.push_back({q, mv[0], mv[0] ? q : 7'h00, ae_s[q], pr_s[q], fw ? ef_s[old] : ef_s[q]});
    if (p == 0) on.push_back({fw && !ef_s[q], ef_s[q]});
    else wn.push_back({q, mv[1], mv[1] ? q : 7'h00, 3'h0});
    if (p == 0) rd_port.go(q, e, m, c);
    else wr_port.go(q, e, m, c);
  endtask : sw

  // a result shows once busy drops; oldest note is the one due
  always @(negedge clk_in)
  begin
    if (rb_d && !rb) check({rq, rmv, rmv ? rmq : 7'h00, ae, pr, ef}, rn.pop_front());
    if (wb_d && !wb) check({wq, wmv, wmv ? wmq : 7'h00, 3'h0}, wn.pop_front());
    if (ri === 1'b1) ill_seen++;
    if (wi === 1'b1) ill_seen++;
    // one cycle after the switch both ready and empty describe the new queue
    if (or_due) check(18'({ordy, ef}), 18'(on.pop_front()));
    or_due = rb_d && !rb;
    rps = 1'($urandom);
    wps = 1'($urandom);
    rb_d = rb;
    wb_d = wb;
  end

  task results;
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : results

  // cut a hang short well past the expected run of about 140 cycles
  initial
  begin
    #200000;
    failures++;
    results();
  end

  initial
  begin
    void'($urandom(74672));
    ae_s = {$urandom, $urandom, $urandom, $urandom};
    pr_s = {$urandom, $urandom, $urandom, $urandom};
    ef_s = {$urandom, $urandom, $urandom, $urandom};
    repeat (4) @(negedge clk_in);
    rst_in = 1'b0;
    repeat (10) sw(0, 7'($urandom), 1'($urandom), 1'($urandom), 1'($urandom));
    $display("random read switching done");
    // let the last flags settle before the mode changes
    repeat (2) @(negedge clk_in);
    fw = 1'b1;
    pm = 1'b1;
    repeat (6) sw(0, 7'($urandom), 1'($urandom), 1'($urandom), 1'($urandom));
    repeat (2) @(negedge clk_in);
    fw = 1'b0;
    $display("fall-through switching done");
    // both ports at once; the write side sees the same random mix
    repeat (8)
    fork
      sw(0, 7'($urandom), 1'($urandom), 1'($urandom), 1'($urandom));
      sw(1, 7'($urandom), 1'($urandom), 1'($urandom), 1'($urandom));
    join
    $display("simultaneous switching done");
    // self switches: ignore, add, illegal keep, keep, remove
    sw(0, 7'h05, 1'b0, 1'b0, 1'b1);
    for (int i = 0; i < 5; i++) sw(0, 7'h05, se[i], sm[i], 1'b1);
    $display("self switching done");
    // both ports mark the same queue together
    fork
      sw(0, 7'h2A, 1'b0, 1'b1, 1'b0);
      sw(1, 7'h2A, 1'b1, 1'b1, 1'b0);
    join
    repeat (4) @(negedge clk_in);
    check(18'(ill_seen), 18'(n_ill));
    $display("shared mark done");
    results();
  end
endmodule : tb_top
`default_nettype wire
